// *** shared/rbo_pkg.sv ***
package rbo_pkg;
	// ----------------------------------------------------------------
	// Register addresses and field positions
	// ----------------------------------------------------------------
	localparam logic [31:0] OPTION_INDEX_ADDR = 32'h4000_03F8;
	localparam logic [31:0] OPTION_DATA_ADDR = 32'h4000_03FC;
	localparam logic [31:0] AHB_GATES_ADDR = 32'h4000_0300;
	localparam logic [31:0] FLASH_CTRL_ADDR = 32'h4000_03CC;
	localparam logic [31:0] CLOCK_CTRL_ADDR = 32'h4000_0380;
	localparam logic [7:0] IDX_MAP0 = 8'hC1;
	localparam logic [7:0] IDX_MAP1 = 8'hC2;
	localparam logic [31:0] AHB_GATES_RESET = 32'h0020_0000;
	localparam logic [31:0] AHB_GATES_WMASK = 32'h0070_0007;
	localparam logic [7:0] MAP0_MASK = 8'h07;
	localparam logic [7:0] MAP1_MASK = 8'hE3;
	localparam logic [7:0] MAP1_WMASK = 8'hC0;
	localparam int OPT_CLK_EN_BIT = 2;
	localparam int UV_OFF_BIT = 2;
	localparam int WDT_EN_BIT = 7;
	localparam int DBG_REL_BIT = 6;
	localparam int RPIN_REL_BIT = 5;
	localparam int SW_RST_BIT = 8;
	localparam int SR_BOOT_LSB = 9;
	localparam int CLK_SW_BIT = 7;
	localparam int CLK_INTEN_BIT = 15;
	localparam int CLK_STOP_BIT = 16;
	localparam logic [1:0] SRC_SLOW_INT = 2'h0;
	localparam logic [1:0] BOOT_MAIN = 2'h0;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned UV_DEGLITCH_NS = 30000;
	localparam int unsigned UV_DEGLITCH_CYC =
		(UV_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned EXT_RST_MIN_NS = 1000;
	localparam int unsigned EXT_RST_MIN_CYC =
		(EXT_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WARMUP_CYC = 64;
	localparam int unsigned BYTE_GAP_CYC = 8;
	localparam int unsigned OPTION_BYTES = 2;
	localparam int unsigned SYSTICK_DIV = 8;
	// ----------------------------------------------------------------
	// Sequencer phases
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {PH_HOLD, PH_LOAD, PH_RUN} rbo_phase_type;
endpackage : rbo_pkg

// *** src/rbo_persist.sv ***
`timescale 1ns/1ps
module rbo_persist #(
	parameter int unsigned COUNT = rbo_pkg::UV_DEGLITCH_CYC
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic level_in,
	output logic fired
);
	typedef struct packed {
		logic [15:0] cnt;
		logic fired;
	} rbo_persist_type;
	rbo_persist_type st_reg, st_next;

	// ----------------------------------------------------------------
	// Persistence counter
	// ----------------------------------------------------------------
	// A glitch restarts the count, so only a steady level fires
	always_comb begin
		st_next = st_reg;
		if (!level_in) begin
			st_next = '0;
		end else if (st_reg.cnt == 16'(COUNT)) begin
			st_next.fired = 1'b1;
		end else begin
			st_next.cnt = st_reg.cnt + 16'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign fired = st_reg.fired;

	a_persist_span: assert property (@(posedge ref_clk) disable iff (!rstn)
		$rose(fired) |-> $past(level_in) && $past(st_reg.cnt) == 16'(COUNT))
		else $error("fired before the level persisted");
endmodule : rbo_persist

// *** src/rbo_loader.sv ***
`timescale 1ns/1ps
module rbo_loader #(
	parameter int unsigned WARM = rbo_pkg::WARMUP_CYC,
	parameter int unsigned GAP = rbo_pkg::BYTE_GAP_CYC,
	parameter int unsigned NBYTES = rbo_pkg::OPTION_BYTES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic run,
	input wire logic [7:0] flash_data,
	output logic flash_req,
	output logic [7:0] flash_addr,
	output logic byte_valid,
	output logic [7:0] byte_index,
	output logic [7:0] byte_data,
	output logic done
);
	typedef struct packed {
		logic [15:0] cnt;
		logic warm;
		logic [7:0] idx;
		logic req;
		logic pend;
		logic bvalid;
		logic [7:0] bidx;
		logic [7:0] bdata;
		logic done;
	} rbo_loader_type;
	rbo_loader_type st_reg, st_next;

	// ----------------------------------------------------------------
	// Warm-up count, then one byte every GAP + 2 cycles
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.req = 1'b0;
		st_next.bvalid = 1'b0;
		if (!run) begin
			st_next = '0;
		end else if (!st_reg.done) begin
			if (st_reg.req) begin
				st_next.pend = 1'b1;
			end
			// Flash answers one cycle after the request
			if (st_reg.pend) begin
				st_next.pend = 1'b0;
				st_next.bvalid = 1'b1;
				st_next.bidx = st_reg.idx;
				st_next.bdata = flash_data;
				st_next.idx = st_reg.idx + 8'h1;
				st_next.done = st_reg.idx == 8'(NBYTES - 1);
			end
			if (!st_reg.warm) begin
				if (st_reg.cnt == 16'(WARM - 1)) begin
					st_next.warm = 1'b1;
					st_next.cnt = '0;
				end else begin
					st_next.cnt = st_reg.cnt + 16'h1;
				end
			end else if (!st_reg.req && !st_reg.pend) begin
				if (st_reg.cnt == 16'(GAP - 1)) begin
					st_next.req = 1'b1;
					st_next.cnt = '0;
				end else begin
					st_next.cnt = st_reg.cnt + 16'h1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign flash_req = st_reg.req;
	assign flash_addr = st_reg.idx;
	assign byte_valid = st_reg.bvalid;
	assign byte_index = st_reg.bidx;
	assign byte_data = st_reg.bdata;
	assign done = st_reg.done;

	a_warm_cleared: assert property (@(posedge ref_clk) disable iff (!rstn)
		ce && !run |=> st_reg.cnt == 16'h0 && !done && !flash_req)
		else $error("warm-up not cleared while held");
endmodule : rbo_loader

// *** src/rbo_seq.sv ***
`timescale 1ns/1ps
module rbo_seq #(
	parameter int unsigned UV_CYCLES = rbo_pkg::UV_DEGLITCH_CYC,
	parameter int unsigned EXT_CYCLES = rbo_pkg::EXT_RST_MIN_CYC,
	parameter int unsigned WARM_CYCLES = rbo_pkg::WARMUP_CYC,
	parameter int unsigned GAP_CYCLES = rbo_pkg::BYTE_GAP_CYC
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic supply_ok,
	input wire logic fast_osc_ready,
	input wire logic [3:0] uv_below,
	input wire logic ext_reset_pin_n,
	input wire logic wdt_expired,
	input wire logic clock_fail,
	input wire logic [3:0] source_stable,
	input wire logic [7:0] flash_data,
	output logic flash_req,
	output logic [7:0] flash_addr,
	output logic sys_reset_n,
	output logic fetch_enable,
	output logic [1:0] boot_area,
	output logic [1:0] uv_level,
	output logic uv_off,
	output logic wdt_enable,
	output logic debug_pins_dedicated,
	output logic reset_pin_is_reset,
	output logic sram_valid,
	output logic [1:0] clock_source_sel,
	output logic clock_switched,
	output logic systick_ref,
	output logic osc_stop_irq
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		rbo_pkg::rbo_phase_type phase;
		logic sw_cause;
		logic [7:0] opt_idx;
		logic [7:0] map0;
		logic [7:0] map1;
		logic [31:0] gates;
		logic [1:0] sr_boot;
		logic [1:0] clk_sel;
		logic clk_sw;
		logic inten;
		logic stop;
		logic irq;
		logic ack;
		logic [31:0] rdata;
		logic rst_n;
		logic fetch;
		logic [1:0] boot;
		logic wdt_en;
		logic dbg_ded;
		logic rpin_rst;
		logic sram_ok;
		logic [1:0] tick_cnt;
		logic tick;
		logic ld_run;
	} rbo_seq_state_type;
	rbo_seq_state_type st_reg, st_next;

	logic uv_in, ext_in, uv_fire, ext_fire;
	logic ld_valid, ld_done;
	logic [7:0] ld_index, ld_data;
	logic bus_hit, bus_wr, evt_sw, evt_hw, go_hold, run_ph;
	logic [31:0] wr32;

	// Byte-lane merge limited to the writable bits
	function automatic logic [31:0] rbo_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] sel,
		input logic [31:0] wmask);
		logic [31:0] m;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = wmask[i*8 +: 8] & {8{sel[i]}};
		end
		return (old & ~m) | (wd & m);
	endfunction : rbo_merge

	// ----------------------------------------------------------------
	// Reset sources
	// ----------------------------------------------------------------
	assign run_ph = st_reg.phase == rbo_pkg::PH_RUN;
	// Threshold comparator chosen by the loaded level code
	assign uv_in = run_ph && !st_reg.map0[rbo_pkg::UV_OFF_BIT]
		&& uv_below[st_reg.map0[1:0]];
	// Pin only counts while it is configured as reset
	assign ext_in = run_ph && !st_reg.map1[rbo_pkg::RPIN_REL_BIT]
		&& !ext_reset_pin_n;

	rbo_persist #(.COUNT(UV_CYCLES)) u_uv_filter (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.ce(ce),
		.level_in(uv_in),
		.fired(uv_fire)
	);

	rbo_persist #(.COUNT(EXT_CYCLES)) u_pin_filter (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.ce(ce),
		.level_in(ext_in),
		.fired(ext_fire)
	);

	rbo_loader #(
		.WARM(WARM_CYCLES),
		.GAP(GAP_CYCLES),
		.NBYTES(rbo_pkg::OPTION_BYTES)
	) u_loader (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.ce(ce),
		.run(st_reg.ld_run),
		.flash_data(flash_data),
		.flash_req(flash_req),
		.flash_addr(flash_addr),
		.byte_valid(ld_valid),
		.byte_index(ld_index),
		.byte_data(ld_data),
		.done(ld_done)
	);

	// ----------------------------------------------------------------
	// Bus decode and reset events
	// ----------------------------------------------------------------
	assign bus_hit = wb_cyc_i && wb_stb_i && !st_reg.ack;
	assign bus_wr = bus_hit && wb_we_i && run_ph;
	assign evt_sw = bus_wr && wb_adr_i == rbo_pkg::FLASH_CTRL_ADDR
		&& wb_sel_i[1] && wb_dat_i[rbo_pkg::SW_RST_BIT];
	assign evt_hw = run_ph && (uv_fire || ext_fire
		|| (wdt_expired && st_reg.wdt_en));
	assign go_hold = evt_sw || evt_hw || !supply_ok;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		wr32 = 32'h0000_0000;
		st_next.ack = bus_hit;
		st_next.rdata = 32'h0000_0000;
		// Reads answer in every phase; unmapped reads give zero
		if (bus_hit && !wb_we_i) begin
			case (wb_adr_i)
				rbo_pkg::OPTION_INDEX_ADDR:
					st_next.rdata = {24'h00_0000, st_reg.opt_idx};
				rbo_pkg::OPTION_DATA_ADDR: begin
					if (st_reg.opt_idx == rbo_pkg::IDX_MAP0) begin
						st_next.rdata = {24'h00_0000, st_reg.map0};
					end else if (st_reg.opt_idx == rbo_pkg::IDX_MAP1) begin
						st_next.rdata = {24'h00_0000, st_reg.map1};
					end
				end
				rbo_pkg::AHB_GATES_ADDR:
					st_next.rdata = st_reg.gates;
				rbo_pkg::FLASH_CTRL_ADDR:
					st_next.rdata = {21'h00_0000, st_reg.sr_boot, 9'h000};
				rbo_pkg::CLOCK_CTRL_ADDR:
					st_next.rdata = {15'h0000, st_reg.stop, st_reg.inten,
						7'h00, st_reg.clk_sw, 5'h00, st_reg.clk_sel};
				default: st_next.rdata = 32'h0000_0000;
			endcase
		end
		unique case (st_reg.phase)
			rbo_pkg::PH_HOLD: begin
				// Wait for supply above the power-on level and oscillator
				if (supply_ok && fast_osc_ready) begin
					st_next.phase = rbo_pkg::PH_LOAD;
					st_next.ld_run = 1'b1;
				end
			end
			rbo_pkg::PH_LOAD: begin
				// Stored bytes overwrite any temporary changes
				if (ld_valid && ld_index == 8'h00) begin
					st_next.map0 = ld_data & rbo_pkg::MAP0_MASK;
				end else if (ld_valid) begin
					st_next.map1 = ld_data & rbo_pkg::MAP1_MASK;
				end
				if (ld_done) begin
					st_next.phase = rbo_pkg::PH_RUN;
					st_next.rst_n = 1'b1;
					st_next.fetch = 1'b1;
					st_next.sram_ok = 1'b1;
					st_next.boot = st_reg.sw_cause ? st_reg.sr_boot
						: st_next.map1[1:0];
				end
			end
			rbo_pkg::PH_RUN: begin
				if (bus_wr) begin
					case (wb_adr_i)
						rbo_pkg::OPTION_INDEX_ADDR: begin
							wr32 = rbo_merge({24'h00_0000, st_reg.opt_idx},
								wb_dat_i, wb_sel_i, 32'h0000_00FF);
							st_next.opt_idx = wr32[7:0];
						end
						rbo_pkg::OPTION_DATA_ADDR: begin
							// Only live copies change; gated by option clock
							if (st_reg.gates[rbo_pkg::OPT_CLK_EN_BIT]
								&& wb_sel_i[0]) begin
								if (st_reg.opt_idx == rbo_pkg::IDX_MAP0) begin
									st_next.map0 = wb_dat_i[7:0]
										& rbo_pkg::MAP0_MASK;
								end else if (st_reg.opt_idx == rbo_pkg::IDX_MAP1) begin
									// Reset-pin use and boot area stay read-only
									st_next.map1 = (st_reg.map1
										& ~rbo_pkg::MAP1_WMASK)
										| (wb_dat_i[7:0]
										& rbo_pkg::MAP1_WMASK);
								end
							end
						end
						rbo_pkg::AHB_GATES_ADDR:
							st_next.gates = rbo_merge(st_reg.gates, wb_dat_i,
								wb_sel_i, rbo_pkg::AHB_GATES_WMASK);
						rbo_pkg::FLASH_CTRL_ADDR: begin
							if (wb_sel_i[1]) begin
								st_next.sr_boot = wb_dat_i[rbo_pkg::SR_BOOT_LSB
									+: 2];
							end
						end
						rbo_pkg::CLOCK_CTRL_ADDR: begin
							// Target picked only while on the fast oscillator
							if (wb_sel_i[0] && !st_reg.clk_sw) begin
								st_next.clk_sel = wb_dat_i[1:0];
							end
							if (wb_sel_i[0] && !wb_dat_i[rbo_pkg::CLK_SW_BIT]) begin
								st_next.clk_sw = 1'b0;
							end else if (wb_sel_i[0] && !st_reg.clk_sw) begin
								st_next.clk_sw =
									source_stable[st_next.clk_sel];
							end
							if (wb_sel_i[1]) begin
								st_next.inten = wb_dat_i[rbo_pkg::CLK_INTEN_BIT];
							end
							if (wb_sel_i[2] && wb_dat_i[rbo_pkg::CLK_STOP_BIT]) begin
								st_next.stop = 1'b0;
							end
						end
						default: st_next.opt_idx = st_reg.opt_idx;
					endcase
				end
				// Failure flag set after the clear, so the set wins
				if (clock_fail && st_reg.clk_sw
					&& st_reg.clk_sel != rbo_pkg::SRC_SLOW_INT) begin
					st_next.stop = 1'b1;
				end
			end
			default: st_next.phase = rbo_pkg::PH_HOLD;
		endcase
		// Bus clock divided by 8, square wave
		if (st_reg.phase != rbo_pkg::PH_HOLD) begin
			st_next.tick_cnt = st_reg.tick_cnt + 2'h1;
			if (st_reg.tick_cnt == 2'(rbo_pkg::SYSTICK_DIV / 2 - 1)) begin
				st_next.tick = !st_reg.tick;
			end
		end
		// Every reset source re-enters the hold phase and reloads options
		if (go_hold) begin
			st_next.phase = rbo_pkg::PH_HOLD;
			st_next.ld_run = 1'b0;
			st_next.rst_n = 1'b0;
			st_next.fetch = 1'b0;
			st_next.opt_idx = 8'h00;
			st_next.gates = rbo_pkg::AHB_GATES_RESET;
			st_next.clk_sel = rbo_pkg::SRC_SLOW_INT;
			st_next.clk_sw = 1'b0;
			st_next.inten = 1'b0;
			st_next.stop = 1'b0;
			st_next.tick_cnt = 2'h0;
			st_next.tick = 1'b0;
			// Hardware causes win over a same-cycle software reset
			st_next.sw_cause = evt_sw && !evt_hw && supply_ok;
		end
		// Only a supply drop loses SRAM; warm resets keep it
		if (!supply_ok) begin
			st_next.sram_ok = 1'b0;
		end
		st_next.wdt_en = st_next.phase == rbo_pkg::PH_RUN
			&& st_next.map1[rbo_pkg::WDT_EN_BIT];
		st_next.dbg_ded = !st_next.map1[rbo_pkg::DBG_REL_BIT];
		st_next.rpin_rst = !st_next.map1[rbo_pkg::RPIN_REL_BIT];
		st_next.irq = st_next.stop && st_next.inten;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
			st_reg.gates <= rbo_pkg::AHB_GATES_RESET;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign wb_dat_o = st_reg.rdata;
	assign wb_ack_o = st_reg.ack;
	assign sys_reset_n = st_reg.rst_n;
	assign fetch_enable = st_reg.fetch;
	assign boot_area = st_reg.boot;
	assign uv_level = st_reg.map0[1:0];
	assign uv_off = st_reg.map0[rbo_pkg::UV_OFF_BIT];
	assign wdt_enable = st_reg.wdt_en;
	assign debug_pins_dedicated = st_reg.dbg_ded;
	assign reset_pin_is_reset = st_reg.rpin_rst;
	assign sram_valid = st_reg.sram_ok;
	assign clock_source_sel = st_reg.clk_sel;
	assign clock_switched = st_reg.clk_sw;
	assign systick_ref = st_reg.tick;
	assign osc_stop_irq = st_reg.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	sequence s_port_write;
		ce && bus_wr && wb_adr_i == rbo_pkg::OPTION_DATA_ADDR;
	endsequence
	sequence s_port_read_map0;
		ce && bus_hit && !wb_we_i && wb_adr_i == rbo_pkg::OPTION_DATA_ADDR
		&& st_reg.opt_idx == rbo_pkg::IDX_MAP0;
	endsequence

	a_port_gated: assert property (s_port_write
		##0 !st_reg.gates[rbo_pkg::OPT_CLK_EN_BIT] |=> $stable(st_reg.map0)
		&& $stable(st_reg.map1)) else $error("gated write changed map");
	a_index_read: assert property (s_port_read_map0 |=> wb_ack_o
		&& wb_dat_o == {24'h00_0000, $past(st_reg.map0)})
		else $error("index C1 read wrong data");
	a_soft_reset: assert property (ce && evt_sw |=> !sys_reset_n
		&& !fetch_enable && st_reg.phase == rbo_pkg::PH_HOLD)
		else $error("software reset not taken");
	a_boot_soft: assert property ($rose(sys_reset_n) && st_reg.sw_cause
		|-> boot_area == st_reg.sr_boot)
		else $error("wrong boot area after software reset");
	a_boot_option: assert property ($rose(sys_reset_n) && !st_reg.sw_cause
		|-> boot_area == st_reg.map1[1:0])
		else $error("wrong boot area after hardware reset");
	a_fetch_order: assert property ($rose(fetch_enable) |-> $past(ld_done)
		&& sys_reset_n) else $error("fetch before loading ended");
	a_wdt_held: assert property (!sys_reset_n |-> !wdt_enable)
		else $error("watchdog enabled in reset");
	a_wdt_option: assert property (sys_reset_n
		|-> wdt_enable == st_reg.map1[rbo_pkg::WDT_EN_BIT])
		else $error("watchdog enable differs from option");
	a_uv_off: assert property (uv_off |-> !uv_in)
		else $error("disabled undervoltage still watched");
	a_pin_reset: assert property (ce && run_ph && ext_fire
		|=> !sys_reset_n) else $error("pin reset not taken");
	a_stop_flag: assert property (ce && run_ph && !go_hold && clock_fail
		&& st_reg.clk_sw && st_reg.clk_sel != rbo_pkg::SRC_SLOW_INT
		|=> st_reg.stop) else $error("clock failure flag not set");
	a_tick_half: assert property ($rose(systick_ref)
		##0 (ce && !go_hold)[*4] ##1 1'b1
		|-> $fell(systick_ref))
		else $error("system tick not divided by eight");
	a_opt_load: assert property (ce && !go_hold && ld_valid
		&& ld_index == 8'h00 && st_reg.phase == rbo_pkg::PH_LOAD
		|=> st_reg.map0 == ($past(ld_data) & rbo_pkg::MAP0_MASK))
		else $error("option byte not loaded");
endmodule : rbo_seq

// *** test/test_rbo_seq.sv ***
`timescale 1ns/1ps
module test_rbo_seq;
	// ----------------------------------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic supply = 1'b0;
	logic pin_n = 1'b1;
	logic wdt_exp = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_adr = 32'h0;
	logic [31:0] wb_wdat = 32'h0;
	logic [31:0] wb_dat_o;
	logic [31:0] rd;
	logic wb_ack_o, flash_req, sys_reset_n, fetch_enable, uv_off;
	logic wdt_enable, dbg_ded, rpin_rst, sram_valid, systick_ref;
	logic [1:0] boot_area, uv_level;
	logic [7:0] flash_data = 8'h00;
	logic [7:0] flash_addr;
	logic [7:0] opt [2] = '{8'h06, 8'hC1};
	logic ce = 1'b1;
	logic osc_rdy = 1'b1;
	logic [3:0] uv_below = 4'h0;
	logic clk_fail = 1'b0;
	logic [3:0] src_ok = 4'h0;
	logic [1:0] clk_sel;
	logic clk_sw, stop_irq;
	int fail_count = 0;
	int compares = 0;

	// Clock at 100 MHz
	always #5 ref_clk = ~ref_clk;

	// Option flash: byte valid the cycle after a request, scrambled else
	always @(posedge ref_clk) begin
		flash_data <= flash_req ? opt[flash_addr[0]] : ~flash_data;
	end

	// Short counts keep the run brief; fixed supply-side inputs tied
	rbo_seq #(.UV_CYCLES(8), .EXT_CYCLES(4), .WARM_CYCLES(4),
		.GAP_CYCLES(2)) u_dut (.ref_clk(ref_clk), .rstn(rstn),
		.ce(ce), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .supply_ok(supply),
		.fast_osc_ready(osc_rdy), .uv_below(uv_below),
		.ext_reset_pin_n(pin_n), .wdt_expired(wdt_exp),
		.clock_fail(clk_fail), .source_stable(src_ok),
		.flash_data(flash_data), .flash_req(flash_req),
		.flash_addr(flash_addr), .sys_reset_n(sys_reset_n),
		.fetch_enable(fetch_enable), .boot_area(boot_area),
		.uv_level(uv_level), .uv_off(uv_off), .wdt_enable(wdt_enable),
		.debug_pins_dedicated(dbg_ded), .reset_pin_is_reset(rpin_rst),
		.sram_valid(sram_valid), .clock_source_sel(clk_sel),
		.clock_switched(clk_sw), .systick_ref(systick_ref),
		.osc_stop_irq(stop_irq));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask : check

	task automatic ran_out;
		fail_count++;
		$display("mismatch at %0t: wait ran out", $time);
		report_and_stop();
	endtask : ran_out

	// Classic cycle; entered just after a rising edge, ends on one
	task automatic wb(input logic we, input logic [31:0] adr,
		input logic [31:0] dat);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_sel <= 4'hF;
		wb_wdat <= dat;
		for (int n = 0; n <= 50; n++) begin
			@(posedge ref_clk);
			if (wb_ack_o === 1'b1) break;
			if (n == 50) ran_out();
		end
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge ref_clk);
	endtask : wb

	// Bounded wait for the internal reset to reach a level
	task automatic wait_reset(input logic lvl);
		for (int n = 0; n < 400; n++) begin
			@(posedge ref_clk);
			if (sys_reset_n === lvl) return;
		end
		ran_out();
	endtask : wait_reset

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_power_up;
		rstn <= 1'b1;
		repeat (20) @(posedge ref_clk);
		check(32'(sys_reset_n), 32'h0);
		supply <= 1'b1;
		wait_reset(1'b1);
		check(32'({uv_off, uv_level}), 32'h6);
		check(32'({wdt_enable, dbg_ded, rpin_rst}), 32'h5);
		check(32'({fetch_enable, boot_area}), 32'h5);
		$display("test power_up done");
	endtask : t_power_up

	task automatic t_mapping;
		wb(1'b0, rbo_pkg::AHB_GATES_ADDR, 32'h0);
		check(rd, rbo_pkg::AHB_GATES_RESET);
		wb(1'b1, rbo_pkg::OPTION_INDEX_ADDR, 32'(rbo_pkg::IDX_MAP0));
		wb(1'b1, rbo_pkg::OPTION_DATA_ADDR, 32'h3);
		check(32'(uv_level), 32'h2);
		wb(1'b1, rbo_pkg::AHB_GATES_ADDR, 32'h0020_0004);
		wb(1'b1, rbo_pkg::OPTION_DATA_ADDR, 32'h3);
		wb(1'b0, rbo_pkg::OPTION_DATA_ADDR, 32'h0);
		check(rd, 32'h3);
		check(32'(uv_level), 32'h3);
		wb(1'b1, rbo_pkg::OPTION_INDEX_ADDR, 32'(rbo_pkg::IDX_MAP1));
		wb(1'b1, rbo_pkg::OPTION_DATA_ADDR, 32'h23);
		wb(1'b0, rbo_pkg::OPTION_DATA_ADDR, 32'h0);
		check(rd, 32'h1);
		check(32'({wdt_enable, dbg_ded}), 32'h1);
		wb(1'b0, 32'h4000_0004, 32'h0);
		check(rd, 32'h0);
		$display("test mapping done");
	endtask : t_mapping

	task automatic t_soft_reset;
		wb(1'b1, rbo_pkg::FLASH_CTRL_ADDR, 32'h0000_0500);
		wait_reset(1'b0);
		wait_reset(1'b1);
		check(32'({wdt_enable, uv_level}), 32'h6);
		check(32'(boot_area), 32'h2);
		check(32'(sram_valid), 32'h1);
		wb(1'b0, rbo_pkg::AHB_GATES_ADDR, 32'h0);
		check(rd, rbo_pkg::AHB_GATES_RESET);
		$display("test soft_reset done");
	endtask : t_soft_reset

	task automatic t_hw_reset;
		wdt_exp <= 1'b1;
		@(posedge ref_clk);
		wdt_exp <= 1'b0;
		wait_reset(1'b0);
		wait_reset(1'b1);
		check(32'(boot_area), 32'h1);
		pin_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		pin_n <= 1'b1;
		repeat (8) @(posedge ref_clk);
		check(32'(sys_reset_n), 32'h1);
		pin_n <= 1'b0;
		// Short enough that the reload cannot have ended yet
		repeat (12) @(posedge ref_clk);
		check(32'(sys_reset_n), 32'h0);
		pin_n <= 1'b1;
		wait_reset(1'b1);
		check(32'({sram_valid, boot_area}), 32'h5);
		$display("test hw_reset done");
	endtask : t_hw_reset

	task automatic t_uv;
		uv_below <= 4'hF;
		repeat (12) @(posedge ref_clk);
		check(32'(sys_reset_n), 32'h1);
		wb(1'b1, rbo_pkg::AHB_GATES_ADDR, 32'h0020_0004);
		wb(1'b1, rbo_pkg::OPTION_INDEX_ADDR, 32'(rbo_pkg::IDX_MAP0));
		wb(1'b1, rbo_pkg::OPTION_DATA_ADDR, 32'h2);
		wait_reset(1'b0);
		uv_below <= 4'h0;
		wait_reset(1'b1);
		check(32'({sram_valid, uv_off}), 32'h3);
		$display("test uv done");
	endtask : t_uv

	task automatic t_clock;
		logic p;
		src_ok <= 4'h2;
		wb(1'b1, rbo_pkg::CLOCK_CTRL_ADDR, 32'h0000_8081);
		check(32'({clk_sw, clk_sel}), 32'h5);
		clk_fail <= 1'b1;
		@(posedge ref_clk);
		clk_fail <= 1'b0;
		@(posedge ref_clk);
		check(32'(stop_irq), 32'h1);
		wb(1'b1, rbo_pkg::CLOCK_CTRL_ADDR, 32'h0001_8081);
		check(32'(stop_irq), 32'h0);
		// Clock enable low must freeze the tick divider
		ce <= 1'b0;
		@(posedge ref_clk);
		p = systick_ref;
		repeat (6) @(posedge ref_clk);
		check(32'(systick_ref), 32'(p));
		ce <= 1'b1;
		$display("test clock done");
	endtask : t_clock

	task automatic t_systick;
		logic p;
		int r0;
		int r1;
		r0 = 0;
		r1 = 0;
		p = systick_ref;
		for (int n = 1; n < 40; n++) begin
			@(posedge ref_clk);
			if (systick_ref === 1'b1 && p === 1'b0) begin
				r0 = r1;
				r1 = n;
			end
			p = systick_ref;
		end
		check(32'(r1 - r0), 32'h8);
		$display("test systick done");
	endtask : t_systick

	// Main sequence; reset held for three cycles first
	initial begin
		repeat (3) @(posedge ref_clk);
		t_power_up();
		t_mapping();
		t_soft_reset();
		t_hw_reset();
		t_uv();
		t_clock();
		t_systick();
		report_and_stop();
	end
endmodule : test_rbo_seq
